// ### hw/scsp_pkg.sv
// constants and types for the system clock select and prescale block
// assumes one ref_clk domain, apb slave with 8-bit byte address
//
// Contract
// - system source codes 0..4, 5..7 reserved
// - switch: two old cycles, two new cycles
// - refuse switch to source not ready
// - old source held enabled until switch ends
// - source field needs protected write
// - prescaler register needs protected write
// - first stage codes 0, odd 1..17
// - first stage rewritable during operation
// - second/third stage code decode
// - stage chain: quad, double, single rate
// - lock blocks source and prescaler changes
// - lock set only by protected write
// - lock cleared only by reset
// - counter clock source codes, 3 and 4 reserved
// - counter clock gated by its enable
// - one enable bit per oscillator
// - reset: only default rc enabled
// - multiplier loop ready flag bit 4
// - ready flags bits 3..0 when stable
// - prescaler changes in phase, glitch free
package scsp_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SYS_SEL = 8'h00;
  localparam logic [7:0] IDX_PSC = 8'h01;
  localparam logic [7:0] IDX_LOCK = 8'h02;
  localparam logic [7:0] IDX_RTC = 8'h03;
  localparam logic [7:0] IDX_OSC_EN = 8'h08;
  localparam logic [7:0] IDX_OSC_RDY = 8'h09;
  localparam logic [7:0] IDX_CCP = 8'h10;
  localparam logic [7:0] ADDR_SYS_SEL = 8'(IDX_SYS_SEL * 4);
  localparam logic [7:0] ADDR_PSC = 8'(IDX_PSC * 4);
  localparam logic [7:0] ADDR_LOCK = 8'(IDX_LOCK * 4);
  localparam logic [7:0] ADDR_RTC = 8'(IDX_RTC * 4);
  localparam logic [7:0] ADDR_OSC_EN = 8'(IDX_OSC_EN * 4);
  localparam logic [7:0] ADDR_OSC_RDY = 8'(IDX_OSC_RDY * 4);
  localparam logic [7:0] ADDR_CCP = 8'(IDX_CCP * 4);

  // field positions
  localparam int SRC_LSB = 0;
  localparam int PSA_LSB = 2;
  localparam int PSBC_LSB = 0;
  localparam int RTC_SRC_LSB = 1;
  localparam int RTC_EN_BIT = 0;
  localparam int LOCK_BIT = 0;
  localparam logic [2:0] SRC_MAX = 3'h4;

  // reset values
  localparam logic [4:0] OSC_EN_RST = 5'h01;
  localparam logic [2:0] SRC_RST = 3'h0;

  // protected write: key opens a short window
  localparam logic [7:0] CCP_KEY = 8'hd8;
  localparam logic [2:0] CCP_WINDOW = 3'h4;

  // switch-over phase lengths in cycles
  localparam logic [1:0] SW_OLD_CYC = 2'h2;
  localparam logic [1:0] SW_NEW_CYC = 2'h2;

  localparam int DIV_W = 11;

  typedef enum logic [1:0] {SW_IDLE, SW_OLD, SW_NEW} scsp_sw_e;

  typedef struct packed {
    scsp_sw_e sw;
    logic [1:0] sw_cnt;
    logic [2:0] src;
    logic [2:0] old_src;
    logic [2:0] sel;
    logic run;
    logic [4:0] psa;
    logic [1:0] psbc;
    logic [3:0] exp_a;
    logic [1:0] exp_b;
    logic exp_c;
    logic [DIV_W-1:0] div_cnt;
    logic lock;
    logic [2:0] rtc_src;
    logic rtc_en;
    logic [4:0] osc_en;
    logic [2:0] ccp_cnt;
    logic [4:0] osc_s1;
    logic [4:0] osc_s2;
    logic [5:0] rtc_s1;
    logic [5:0] rtc_s2;
    logic [5:0] rtc_s3;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic per4;
    logic per2;
    logic cpu;
    logic rtc_tick;
  } scsp_state_s;

endpackage : scsp_pkg

// ### hw/scsp_top.sv
// system clock source select, three stage prescaler, counter clock gate
// assumes apb master on ref_clk; oscillator and counter clock levels are
// asynchronous and pass two flip-flops first
`timescale 1ns/1ps
`default_nettype none
module scsp_top import scsp_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] osc_stable,
  input wire logic [5:0] rtc_src_lvl,
  output logic [2:0] sys_src_sel,
  output logic sys_clk_run,
  output logic [4:0] osc_enable,
  output logic per4_tick,
  output logic per2_tick,
  output logic cpu_tick,
  output logic rtc_tick
);

  scsp_state_s r_reg;
  scsp_state_s r_next;
  logic wr;
  logic ccp_open;
  logic [4:0] ready;
  logic [2:0] src_code;
  logic [4:0] psa_code;
  logic [2:0] rtc_code;
  logic cpu_now;

  function automatic logic [4:0] onehot(input logic [2:0] code);
    return (code <= SRC_MAX) ? 5'(5'h01 << code) : 5'h00;
  endfunction : onehot

  function automatic logic [DIV_W-1:0] lowmask(input logic [3:0] k);
    return DIV_W'((12'h001 << k) - 12'h001);
  endfunction : lowmask

  // valid first stage codes: zero or odd up to 17
  function automatic logic psa_valid(input logic [4:0] c);
    return (c == 5'h00) || (c[0] && c <= 5'h11);
  endfunction : psa_valid

  function automatic logic [3:0] psa_exp(input logic [4:0] c);
    return (c == 5'h00) ? 4'h0 : 4'(c[4:1] + 4'h1);
  endfunction : psa_exp

  function automatic logic rtc_valid(input logic [2:0] c);
    return (c != 3'h3) && (c != 3'h4);
  endfunction : rtc_valid

  // counter clock input lane for a source code
  function automatic logic [2:0] rtc_idx(input logic [2:0] c);
    return (c >= 3'h5) ? 3'(c - 3'h2) : c;
  endfunction : rtc_idx

  assign wr = psel & penable & r_reg.pready & pwrite;
  assign ccp_open = (r_reg.ccp_cnt != 3'h0);
  assign ready = r_reg.osc_s2 & r_reg.osc_en;
  assign src_code = pwdata[SRC_LSB +: 3];
  assign psa_code = pwdata[PSA_LSB +: 5];
  assign rtc_code = pwdata[RTC_SRC_LSB +: 3];
  assign cpu_now = &(r_reg.div_cnt |
    ~lowmask(4'(r_reg.exp_a + 4'(r_reg.exp_b) + 4'(r_reg.exp_c))));

  always_comb begin
    r_next = r_reg;
    r_next.osc_s1 = osc_stable;
    r_next.osc_s2 = r_reg.osc_s1;
    r_next.rtc_s1 = rtc_src_lvl;
    r_next.rtc_s2 = r_reg.rtc_s1;
    r_next.rtc_s3 = r_reg.rtc_s2;

    // answer in the cycle after setup; zero wait states
    r_next.pready = psel & ~penable;
    r_next.pslverr = 1'b0;
    r_next.prdata = 32'h0000_0000;
    if (psel && !penable) begin
      case (paddr)
        ADDR_SYS_SEL: r_next.prdata = {29'h0000_0000, r_reg.src};
        ADDR_PSC: r_next.prdata = {25'h000_0000, r_reg.psa, r_reg.psbc};
        ADDR_LOCK: r_next.prdata = {31'h0000_0000, r_reg.lock};
        ADDR_RTC: r_next.prdata = {28'h000_0000, r_reg.rtc_src, r_reg.rtc_en};
        ADDR_OSC_EN: r_next.prdata = {27'h000_0000, r_reg.osc_en};
        ADDR_OSC_RDY: r_next.prdata = {27'h000_0000, ready};
        ADDR_CCP: r_next.prdata = 32'h0000_0000;
        default: r_next.pslverr = 1'b1;
      endcase
    end

    if (ccp_open) begin
      r_next.ccp_cnt = 3'(r_reg.ccp_cnt - 3'h1);
    end

    if (wr) begin
      case (paddr)
        ADDR_CCP: begin
          if (pwdata[7:0] == CCP_KEY) begin
            r_next.ccp_cnt = CCP_WINDOW;
          end
        end
        ADDR_SYS_SEL: begin
          // plain writes fall through untouched
          if (ccp_open) begin
            r_next.ccp_cnt = 3'h0;
            if (!r_reg.lock && r_reg.sw == SW_IDLE &&
                src_code <= SRC_MAX &&
                (onehot(src_code) & ready) != 5'h00 &&
                src_code != r_reg.src) begin
              r_next.src = src_code;
              r_next.sw = SW_OLD;
              r_next.sw_cnt = 2'h0;
            end
          end
        end
        ADDR_PSC: begin
          if (ccp_open) begin
            r_next.ccp_cnt = 3'h0;
            if (!r_reg.lock && psa_valid(psa_code)) begin
              r_next.psa = psa_code;
              r_next.psbc = pwdata[PSBC_LSB +: 2];
            end
          end
        end
        ADDR_LOCK: begin
          if (ccp_open) begin
            r_next.ccp_cnt = 3'h0;
            // a zero never clears it
            r_next.lock = r_reg.lock | pwdata[LOCK_BIT];
          end
        end
        ADDR_RTC: begin
          if (rtc_valid(rtc_code)) begin
            r_next.rtc_src = rtc_code;
            r_next.rtc_en = pwdata[RTC_EN_BIT];
          end
        end
        ADDR_OSC_EN: begin
          r_next.osc_en = pwdata[4:0];
        end
        default: begin
        end
      endcase
    end

    case (r_reg.sw)
      SW_IDLE: begin
      end
      SW_OLD: begin
        if (r_reg.sw_cnt == 2'(SW_OLD_CYC - 2'h1)) begin
          r_next.sw = SW_NEW;
          r_next.sw_cnt = 2'h0;
        end else begin
          r_next.sw_cnt = 2'(r_reg.sw_cnt + 2'h1);
        end
      end
      SW_NEW: begin
        if (r_reg.sw_cnt == 2'(SW_NEW_CYC - 2'h1)) begin
          r_next.sw = SW_IDLE;
          r_next.old_src = r_reg.src;
        end else begin
          r_next.sw_cnt = 2'(r_reg.sw_cnt + 2'h1);
        end
      end
      default: r_next.sw = SW_IDLE;
    endcase

    // the running source and, mid-switch, the one left behind stay on
    r_next.osc_en = r_next.osc_en | onehot(r_next.src) |
      onehot(r_next.old_src);
    r_next.sel = (r_next.sw == SW_OLD) ? r_next.old_src : r_next.src;
    r_next.run = (r_next.sw == SW_IDLE);

    // one shared counter keeps every derived tick in phase; new factors
    // land only on a slowest-clock edge so no short period appears
    r_next.div_cnt = DIV_W'(r_reg.div_cnt + 1'b1);
    if (cpu_now) begin
      r_next.exp_a = psa_exp(r_reg.psa);
      r_next.exp_b = (r_reg.psbc == 2'h2) ? 2'h2 :
        ((r_reg.psbc == 2'h3) ? 2'h1 : 2'h0);
      r_next.exp_c = r_reg.psbc[0];
    end
    r_next.per4 = r_reg.run & (&(r_reg.div_cnt | ~lowmask(r_reg.exp_a)));
    r_next.per2 = r_reg.run & (&(r_reg.div_cnt |
      ~lowmask(4'(r_reg.exp_a + 4'(r_reg.exp_b)))));
    r_next.cpu = r_reg.run & cpu_now;

    // rising edge of the chosen counter clock, after synchronising
    r_next.rtc_tick = r_reg.rtc_en &
      r_reg.rtc_s2[rtc_idx(r_reg.rtc_src)] &
      ~r_reg.rtc_s3[rtc_idx(r_reg.rtc_src)];
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.sw <= SW_IDLE;
      r_reg.src <= SRC_RST;
      r_reg.old_src <= SRC_RST;
      r_reg.sel <= SRC_RST;
      r_reg.run <= 1'b1;
      r_reg.osc_en <= OSC_EN_RST;
    end else if (clk_en) begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign sys_src_sel = r_reg.sel;
  assign sys_clk_run = r_reg.run;
  assign osc_enable = r_reg.osc_en;
  assign per4_tick = r_reg.per4;
  assign per2_tick = r_reg.per2;
  assign cpu_tick = r_reg.cpu;
  assign rtc_tick = r_reg.rtc_tick;

  // frozen cycles would stretch every relation below
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst || !clk_en);

  a_src_legal: assert property (r_reg.src <= SRC_MAX)
    else $error("system source holds a reserved code");

  a_switch_length: assert property (
    (r_reg.sw == SW_IDLE) ##1 (r_reg.sw == SW_OLD) |->
      (r_reg.sw == SW_OLD) [*2] ##1 (r_reg.sw == SW_NEW) [*2] ##1
      (r_reg.sw == SW_IDLE))
    else $error("switch-over did not take two plus two cycles");

  a_ticks_held: assert property (
    !sys_clk_run |=> !per4_tick && !per2_tick && !cpu_tick)
    else $error("derived tick during switch-over");

  a_not_ready_refused: assert property (
    wr && paddr == ADDR_SYS_SEL && (onehot(src_code) & ready) == 5'h00
    |=> $stable(r_reg.src))
    else $error("switched to a source that was not ready");

  a_old_kept_on: assert property (
    r_reg.sw != SW_IDLE |-> (osc_enable & onehot(r_reg.old_src)) != 5'h00
      && (osc_enable & onehot(r_reg.src)) != 5'h00)
    else $error("source disabled during switch-over");

  a_plain_sel_ignored: assert property (
    wr && paddr == ADDR_SYS_SEL && !ccp_open |=> $stable(r_reg.src))
    else $error("unprotected write changed system source");

  a_plain_psc_ignored: assert property (
    wr && paddr == ADDR_PSC && !ccp_open |=>
      $stable(r_reg.psa) && $stable(r_reg.psbc))
    else $error("unprotected write changed prescaler");

  a_psa_legal: assert property (psa_valid(r_reg.psa))
    else $error("first stage holds a reserved code");

  a_tick_nesting: assert property (
    cpu_tick |-> per2_tick && per4_tick)
    else $error("cpu tick without faster ticks");

  a_lock_freezes: assert property (
    r_reg.lock |=> $stable(r_reg.src) && $stable(r_reg.psa) &&
      $stable(r_reg.psbc))
    else $error("locked configuration changed");

  a_lock_sticky: assert property ($past(r_reg.lock) |-> r_reg.lock)
    else $error("lock cleared without reset");

  a_lock_protected: assert property (
    $rose(r_reg.lock) |-> $past(wr && paddr == ADDR_LOCK && ccp_open))
    else $error("lock set without protected write");

  a_rtc_gated: assert property (!r_reg.rtc_en |=> !rtc_tick)
    else $error("counter tick while its clock is disabled");

  a_rtc_legal: assert property (rtc_valid(r_reg.rtc_src))
    else $error("counter source holds a reserved code");

  a_factor_on_edge: assert property (
    !cpu_now |=> $stable(r_reg.exp_a) && $stable(r_reg.exp_b) &&
      $stable(r_reg.exp_c))
    else $error("prescaler factor changed off a slowest-clock edge");

  a_window_bound: assert property (r_reg.ccp_cnt <= CCP_WINDOW)
    else $error("protection window longer than its limit");

  a_rtc_one_cycle: assert property (rtc_tick |=> !rtc_tick)
    else $error("counter tick lasted more than one cycle");

endmodule : scsp_top
`default_nettype wire

// ### verif/test_system_clock_select_prescale.sv
// bench for the clock select and prescale block: apb tasks, tick counters
// assumes scsp_top with zero-wait apb slave and one ref_clk domain
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module test_system_clock_select_prescale import scsp_pkg::*;;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, err, sys_clk_run;
  logic per4_tick, per2_tick, cpu_tick, rtc_tick;
  logic [4:0] osc_stable = 5'h0b;
  logic [4:0] osc_enable;
  logic [5:0] rtc_src_lvl = 6'h00;
  logic [2:0] sys_src_sel;
  int n_mismatch = 0;
  int checked = 0;
  int c4, c2, cc, ct;

  always #25 ref_clk = ~ref_clk;

  scsp_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_stable(osc_stable), .rtc_src_lvl(rtc_src_lvl),
    .sys_src_sel(sys_src_sel), .sys_clk_run(sys_clk_run),
    .osc_enable(osc_enable), .per4_tick(per4_tick), .per2_tick(per2_tick),
    .cpu_tick(cpu_tick), .rtc_tick(rtc_tick));

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    `CHK("pready", 1'b1, pready)
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, '0);
    `CHK("prdata", e, q)
  endtask : rd

  // key write then the target write, spaced within the open window
  task automatic prot(input logic [7:0] a, input logic [31:0] d);
    wr(ADDR_CCP, 32'h0000_00d8);
    wr(a, d);
  endtask : prot

  // samples at the edge, so every one-cycle pulse is seen exactly once
  task automatic count(input int n);
    c4 = 0;
    c2 = 0;
    cc = 0;
    repeat (n) begin
      @(posedge ref_clk);
      c4 += per4_tick;
      c2 += per2_tick;
      cc += cpu_tick;
      ct += rtc_tick;
    end
  endtask : count

  task automatic t_reset();
    logic [7:0] ad[6] = '{ADDR_SYS_SEL, ADDR_PSC, ADDR_LOCK, ADDR_RTC,
                          ADDR_OSC_EN, ADDR_OSC_RDY};
    for (int i = 0; i < 6; i++) begin
      rd(ad[i], 32'(i > 3));
    end
    `CHK("osc_enable", OSC_EN_RST, osc_enable)
    `CHK("sys_src_sel", SRC_RST, sys_src_sel)
    xfer(1'b0, 8'h30, '0);
    `CHK("pslverr", 1'b1, err)
  endtask : t_reset

  task automatic t_switch();
    wr(ADDR_SYS_SEL, 32'h0000_0001);
    rd(ADDR_SYS_SEL, 32'h0000_0000);
    // the running default rc cannot be dropped, so it stays ready
    wr(ADDR_OSC_EN, 32'h0000_0006);
    rd(ADDR_OSC_RDY, 32'h0000_0003);
    prot(ADDR_SYS_SEL, 32'h0000_0002);
    rd(ADDR_SYS_SEL, 32'h0000_0000);
    prot(ADDR_SYS_SEL, 32'h0000_0005);
    rd(ADDR_SYS_SEL, 32'h0000_0000);
    prot(ADDR_SYS_SEL, 32'h0000_0001);
    for (int i = 0; i < 5; i++) begin
      #1;
      `CHK("sys_src_sel", 3'((i < 2) ? 0 : 1), sys_src_sel)
      `CHK("sys_clk_run", 1'(i == 4), sys_clk_run)
      @(posedge ref_clk);
    end
    wr(ADDR_OSC_EN, 32'h0000_0000);
    rd(ADDR_OSC_EN, 32'h0000_0002);
    osc_stable <= 5'h1f;
    // loop factor sits outside this block; its enable comes last
    wr(ADDR_OSC_EN, 32'h0000_001e);
    rd(ADDR_OSC_RDY, 32'h0000_001e);
    prot(ADDR_SYS_SEL, 32'h0000_0004);
    repeat (6) @(posedge ref_clk);
    rd(ADDR_SYS_SEL, 32'h0000_0004);
  endtask : t_switch

  task automatic t_prescale();
    int be[4] = '{0, 0, 2, 1};
    int ce[4] = '{0, 1, 0, 1};
    wr(ADDR_PSC, 32'h0000_0007);
    rd(ADDR_PSC, 32'h0000_0000);
    // stage a fixed at divide 2 so every stage count fits 64 cycles
    for (int b = 0; b < 4; b++) begin
      prot(ADDR_PSC, 32'(4 + b));
      repeat (16) @(posedge ref_clk);
      count(64);
      `CHK("per4_tick", 32, c4)
      `CHK("per2_tick", 64 >> (1 + be[b]), c2)
      `CHK("cpu_tick", 64 >> (1 + be[b] + ce[b]), cc)
    end
    prot(ADDR_PSC, 32'h0000_0044);
    repeat (16) @(posedge ref_clk);
    count(1024);
    `CHK("per4_tick", 2, c4)
    prot(ADDR_PSC, 32'h0000_0054);
    rd(ADDR_PSC, 32'h0000_0044);
  endtask : t_prescale

  task automatic t_rtc();
    logic [2:0] cd[6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    for (int i = 0; i < 7; i++) begin
      // last pass keeps code 7 but drops the enable
      wr(ADDR_RTC, (i < 6) ? 32'({cd[i], 1'b1}) : 32'h0000_000e);
      ct = 0;
      repeat (3) begin
        rtc_src_lvl <= 6'(6'h01 << ((i < 6) ? i : 5));
        count(8);
        rtc_src_lvl <= 6'h00;
        count(8);
      end
      `CHK("rtc_tick", (i < 6) ? 3 : 0, ct)
      if (i == 5) begin
        wr(ADDR_RTC, 32'h0000_0007);
        rd(ADDR_RTC, 32'h0000_000f);
      end
    end
    // a pulse that comes and goes while frozen must leave no trace
    wr(ADDR_RTC, 32'h0000_000f);
    ct = 0;
    clk_en <= 1'b0;
    rtc_src_lvl <= 6'h20;
    count(8);
    rtc_src_lvl <= 6'h00;
    count(8);
    clk_en <= 1'b1;
    rtc_src_lvl <= 6'h20;
    count(8);
    rtc_src_lvl <= 6'h00;
    count(8);
    `CHK("rtc_tick", 1, ct)
  endtask : t_rtc

  task automatic t_lock();
    wr(ADDR_LOCK, 32'h0000_0001);
    rd(ADDR_LOCK, 32'h0000_0000);
    prot(ADDR_LOCK, 32'h0000_0001);
    rd(ADDR_LOCK, 32'h0000_0001);
    prot(ADDR_PSC, 32'h0000_0000);
    rd(ADDR_PSC, 32'h0000_0044);
    prot(ADDR_SYS_SEL, 32'h0000_0001);
    rd(ADDR_SYS_SEL, 32'h0000_0004);
    prot(ADDR_LOCK, 32'h0000_0000);
    rd(ADDR_LOCK, 32'h0000_0001);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(ADDR_LOCK, 32'h0000_0000);
  endtask : t_lock

  task automatic print_verdict();
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_switch();
    t_prescale();
    t_rtc();
    t_lock();
    print_verdict();
  end

  // the whole run needs about 2000 cycles
  initial begin
    repeat (12000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule : test_system_clock_select_prescale
`undef CHK
`default_nettype wire
